//--- hdl/phbp_pkg.sv
package phbp_pkg;
  localparam int PHBP_BUS_W = 8;
  localparam int PHBP_BUF_W = 16;
  localparam int PHBP_NIB_W = 4;
  localparam int PHBP_CTL_W = 5;
  localparam int PHBP_SYNC_W = PHBP_CTL_W + PHBP_BUS_W;
  // positions of synchronised host controls inside the sync vector
  localparam int PHBP_S_CS = 0;
  localparam int PHBP_S_IDS = 1;
  localparam int PHBP_S_ODS = 2;
  localparam int PHBP_S_BSEL = 3;
  localparam int PHBP_S_STAT = 4;
  // status byte layout
  localparam int PHBP_STAT_IBF = 0;
  localparam int PHBP_STAT_OBE = 1;
  localparam logic [PHBP_BUF_W-1:0] PHBP_BUF_RST = 16'h0000;
  localparam logic [PHBP_BUS_W-1:0] PHBP_BYTE_RST = 8'h00;
  localparam logic PHBP_IBF_RST = 1'b0;
  localparam logic PHBP_OBE_RST = 1'b1;

  typedef enum logic [1:0] {
    PHBP_IDLE = 2'b00,
    PHBP_WRITE = 2'b01,
    PHBP_READ = 2'b10
  } phbp_acc_e;

  typedef struct packed {
    phbp_acc_e acc;
    logic hi;
    logic stat;
    logic ibf;
    logic obe;
    logic [PHBP_BUF_W-1:0] in_buf;
    logic [PHBP_BUF_W-1:0] out_buf;
    logic [PHBP_BUS_W-1:0] bus_out;
    logic bus_oe;
    logic flag;
    logic in_event;
    logic out_event;
  } phbp_state_s;
endpackage

//--- hdl/phbp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module phbp_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } phbp_sync_s;

  phbp_sync_s st_q;
  phbp_sync_s st_d;

  // first stage feeds only the second; reset loads the all-ones idle level at once, without waiting for a clock
  always_comb begin
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2 & ({W{1'b1}} | rst_val_i);
endmodule
`default_nettype wire

//--- hdl/phbp_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module phbp_pin_mux
  import phbp_pkg::*;
(
  input wire logic second_serial_enable_bit_i,
  input wire logic bit_io_high_enable_i,
  input wire logic [phbp_pkg::PHBP_BUS_W-1:0] host_out_i,
  input wire logic host_oe_i,
  input wire logic [phbp_pkg::PHBP_NIB_W-1:0] serial_out_i,
  input wire logic [phbp_pkg::PHBP_NIB_W-1:0] serial_oe_i,
  input wire logic [phbp_pkg::PHBP_BUS_W-1:0] bit_io_out_i,
  input wire logic [phbp_pkg::PHBP_BUS_W-1:0] bit_io_oe_i,
  input wire logic [phbp_pkg::PHBP_NIB_W-1:0] vector_i,
  output logic [phbp_pkg::PHBP_BUS_W-1:0] pad_o,
  output logic [phbp_pkg::PHBP_BUS_W-1:0] pad_oe_o,
  output logic [phbp_pkg::PHBP_NIB_W-1:0] vec_pad_o,
  output logic [phbp_pkg::PHBP_NIB_W-1:0] vec_pad_oe_o
);
  import phbp_pkg::*;

  always_comb begin
    if (second_serial_enable_bit_i) begin
      pad_o = {bit_io_out_i[PHBP_NIB_W-1:0], serial_out_i};
      pad_oe_o = {bit_io_oe_i[PHBP_NIB_W-1:0], serial_oe_i};
    end else begin
      pad_o = host_out_i;
      pad_oe_o = {PHBP_BUS_W{host_oe_i}};
    end
    if (second_serial_enable_bit_i && bit_io_high_enable_i) begin
      vec_pad_o = bit_io_out_i[PHBP_BUS_W-1:PHBP_NIB_W];
      vec_pad_oe_o = bit_io_oe_i[PHBP_BUS_W-1:PHBP_NIB_W];
    end else begin
      // vector pins are plain outputs unless the upper bit I/O lines take them
      vec_pad_o = vector_i;
      vec_pad_oe_o = '1;
    end
  end
endmodule
`default_nettype wire

//--- hdl/phbp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module phbp_host_port
  import phbp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  // host pins
  input wire logic host_chip_select_n_i,
  input wire logic input_strobe_n_i,
  input wire logic output_strobe_n_i,
  input wire logic byte_select_i,
  input wire logic status_select_i,
  input wire logic [phbp_pkg::PHBP_BUS_W-1:0] pad_i,
  output logic [phbp_pkg::PHBP_BUS_W-1:0] pad_o,
  output logic [phbp_pkg::PHBP_BUS_W-1:0] pad_oe_o,
  output logic input_full_flag_o,
  output logic output_empty_flag_o,
  input wire logic [phbp_pkg::PHBP_NIB_W-1:0] vec_pad_i,
  output logic [phbp_pkg::PHBP_NIB_W-1:0] vec_pad_o,
  output logic [phbp_pkg::PHBP_NIB_W-1:0] vec_pad_oe_o,
  // configuration
  input wire logic second_serial_enable_bit_i,
  input wire logic bit_io_high_enable_i,
  input wire logic rw_line_mode_i,
  input wire logic data_strobe_active_high_i,
  input wire logic byte_select_invert_i,
  input wire logic combine_flags_i,
  // processor side
  output logic [phbp_pkg::PHBP_BUF_W-1:0] core_in_data_o,
  input wire logic core_in_read_i,
  output logic core_in_event_o,
  input wire logic [phbp_pkg::PHBP_BUF_W-1:0] core_out_data_i,
  input wire logic core_out_write_i,
  output logic core_out_event_o,
  output logic [phbp_pkg::PHBP_BUS_W-1:0] status_o,
  // shared pin users
  input wire logic [phbp_pkg::PHBP_NIB_W-1:0] serial_out_i,
  input wire logic [phbp_pkg::PHBP_NIB_W-1:0] serial_oe_i,
  output logic [phbp_pkg::PHBP_NIB_W-1:0] serial_in_o,
  input wire logic [phbp_pkg::PHBP_BUS_W-1:0] bit_io_out_i,
  input wire logic [phbp_pkg::PHBP_BUS_W-1:0] bit_io_oe_i,
  output logic [phbp_pkg::PHBP_BUS_W-1:0] bit_io_in_o,
  input wire logic [phbp_pkg::PHBP_NIB_W-1:0] vector_i
);
  import phbp_pkg::*;

  phbp_state_s st_q;
  phbp_state_s st_d;
  logic [PHBP_SYNC_W-1:0] sync_raw;
  logic [PHBP_SYNC_W-1:0] sync_v;
  logic [PHBP_BUS_W-1:0] s_data;
  logic s_cs_n;
  logic s_ids;
  logic s_ods;
  logic s_bsel;
  logic s_stat;
  logic host_mode;
  logic sel;
  logic ds_on;
  logic wr_on;
  logic rd_on;
  logic wr_done;
  logic rd_done;
  logic [PHBP_BUS_W-1:0] status_byte;

  // data pins ride the same two stages as the strobes, so the byte seen at the
  // strobe's trailing edge is the byte taken; the host must hold data two clocks
  assign sync_raw = {pad_i, status_select_i, byte_select_i, output_strobe_n_i,
                     input_strobe_n_i, host_chip_select_n_i};

  phbp_sync #(.W(PHBP_SYNC_W)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(sync_raw),
    .rst_val_i('1),
    .sync_o(sync_v)
  );

  assign s_cs_n = sync_v[PHBP_S_CS];
  assign s_ids = sync_v[PHBP_S_IDS];
  assign s_ods = sync_v[PHBP_S_ODS];
  assign s_bsel = sync_v[PHBP_S_BSEL];
  assign s_stat = sync_v[PHBP_S_STAT];
  assign s_data = sync_v[PHBP_SYNC_W-1:PHBP_CTL_W];

  // the serial and bit I/O units synchronise their own inputs
  assign serial_in_o = pad_i[PHBP_NIB_W-1:0];
  assign bit_io_in_o = {vec_pad_i, pad_i[PHBP_BUS_W-1:PHBP_NIB_W]};

  always_comb begin
    host_mode = !second_serial_enable_bit_i;
    sel = host_mode && !s_cs_n;
    ds_on = (s_ods == data_strobe_active_high_i);
    if (rw_line_mode_i) begin
      wr_on = sel && ds_on && !s_ids;
      rd_on = sel && ds_on && s_ids;
    end else begin
      wr_on = sel && !s_ids;
      rd_on = sel && !s_ods;
    end
    status_byte = '0;
    status_byte[PHBP_STAT_IBF] = st_q.ibf;
    status_byte[PHBP_STAT_OBE] = st_q.obe;
  end

  // an access ends on whichever edge (strobe or select) drops it first
  assign wr_done = (st_q.acc == PHBP_WRITE) && !wr_on;
  assign rd_done = (st_q.acc == PHBP_READ) && !rd_on;

  always_comb begin
    st_d = st_q;
    st_d.in_event = 1'b0;
    st_d.out_event = 1'b0;
    unique case (st_q.acc)
      PHBP_IDLE: begin
        st_d.hi = s_bsel ^ byte_select_invert_i;
        st_d.stat = s_stat;
        if (wr_on) begin
          st_d.acc = PHBP_WRITE;
        end else if (rd_on) begin
          st_d.acc = PHBP_READ;
          st_d.bus_oe = 1'b1;
        end
      end
      PHBP_WRITE: begin
        if (wr_done) begin
          st_d.acc = PHBP_IDLE;
          if (st_q.hi) begin
            st_d.in_buf[PHBP_BUF_W-1:PHBP_BUS_W] = s_data;
            st_d.in_event = 1'b1;
          end else begin
            st_d.in_buf[PHBP_BUS_W-1:0] = s_data;
          end
        end
      end
      PHBP_READ: begin
        if (rd_done) begin
          st_d.acc = PHBP_IDLE;
          st_d.bus_oe = 1'b0;
          st_d.out_event = st_q.hi && !st_q.stat;
        end
      end
      default: begin
        st_d.acc = PHBP_IDLE;
        st_d.bus_oe = 1'b0;
      end
    endcase
    if (st_q.stat) begin
      st_d.bus_out = status_byte;
    end else if (st_q.hi) begin
      st_d.bus_out = st_q.out_buf[PHBP_BUF_W-1:PHBP_BUS_W];
    end else begin
      st_d.bus_out = st_q.out_buf[PHBP_BUS_W-1:0];
    end
    if (core_out_write_i) begin
      st_d.out_buf = core_out_data_i;
    end
    // a host event in the same cycle as the processor's access wins
    st_d.ibf = st_d.in_event || (st_q.ibf && !core_in_read_i);
    st_d.obe = st_d.out_event || (st_q.obe && !core_out_write_i);
    st_d.flag = combine_flags_i ? (st_d.ibf || st_d.obe) : st_d.ibf;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.acc <= PHBP_IDLE;
      st_q.hi <= 1'b0;
      st_q.stat <= 1'b0;
      st_q.ibf <= PHBP_IBF_RST;
      st_q.obe <= PHBP_OBE_RST;
      st_q.in_buf <= PHBP_BUF_RST;
      st_q.out_buf <= PHBP_BUF_RST;
      st_q.bus_out <= PHBP_BYTE_RST;
      st_q.bus_oe <= 1'b0;
      st_q.flag <= PHBP_IBF_RST;
      st_q.in_event <= 1'b0;
      st_q.out_event <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  phbp_pin_mux u_mux (
    .second_serial_enable_bit_i(second_serial_enable_bit_i),
    .bit_io_high_enable_i(bit_io_high_enable_i),
    .host_out_i(st_q.bus_out),
    .host_oe_i(st_q.bus_oe),
    .serial_out_i(serial_out_i),
    .serial_oe_i(serial_oe_i),
    .bit_io_out_i(bit_io_out_i),
    .bit_io_oe_i(bit_io_oe_i),
    .vector_i(vector_i),
    .pad_o(pad_o),
    .pad_oe_o(pad_oe_o),
    .vec_pad_o(vec_pad_o),
    .vec_pad_oe_o(vec_pad_oe_o)
  );

  assign input_full_flag_o = st_q.flag;
  assign output_empty_flag_o = st_q.obe;
  assign core_in_data_o = st_q.in_buf;
  assign core_in_event_o = st_q.in_event;
  assign core_out_event_o = st_q.out_event;
  assign status_o = status_byte;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // flags: set by the host side, cleared only by the processor
  AST_IBF_SET: assert property (wr_done && st_q.hi |=> st_q.ibf && core_in_event_o)
    else $error("input full not set after high byte write");
  AST_IBF_CLEAR: assert property (
    core_in_read_i && !(wr_done && st_q.hi) |=> !st_q.ibf)
    else $error("input full not cleared by processor read");
  AST_IBF_HOLD: assert property (
    st_q.ibf && !core_in_read_i |=> st_q.ibf)
    else $error("input full dropped without processor read");
  AST_LOW_NO_EVENT: assert property (
    wr_done && !st_q.hi |=> !core_in_event_o)
    else $error("low byte write raised the input event");
  AST_OBE_SET: assert property (rd_done && st_q.hi && !st_q.stat |=> st_q.obe)
    else $error("output empty not set after host read");
  AST_OBE_CLEAR: assert property (
    core_out_write_i && !(rd_done && st_q.hi && !st_q.stat) |=> !output_empty_flag_o)
    else $error("output empty not cleared by processor write");
  AST_OBE_HOLD: assert property (
    st_q.obe && !core_out_write_i |=> st_q.obe)
    else $error("output empty dropped without processor write");
  AST_OUT_EVENT: assert property (
    rd_done && st_q.hi && !st_q.stat |=> core_out_event_o)
    else $error("output event missing after high byte read");
  AST_OUT_BUF_LOAD: assert property (
    core_out_write_i |=> st_q.out_buf == $past(core_out_data_i))
    else $error("output buffer not loaded by processor write");
  AST_FLAG_COMB: assert property (
    input_full_flag_o == ($past(combine_flags_i) ? (st_q.ibf || st_q.obe) : st_q.ibf))
    else $error("input full pin does not follow combine option");
  AST_STATUS_MAP: assert property (
    status_o[PHBP_STAT_IBF] == st_q.ibf && status_o[PHBP_STAT_OBE] == output_empty_flag_o)
    else $error("status byte does not show the flags");

  // events are single-cycle notices to the core
  AST_IN_PULSE: assert property (
    core_in_event_o |=> !core_in_event_o)
    else $error("input event longer than one cycle");
  AST_OUT_PULSE: assert property (
    core_out_event_o |=> !core_out_event_o)
    else $error("output event longer than one cycle");

  // access sequencing on the host side
  AST_CS_IGNORE: assert property (
    s_cs_n && st_q.acc == PHBP_IDLE |=> st_q.acc == PHBP_IDLE)
    else $error("access started while chip select high");
  AST_HOST_MODE_IGNORE: assert property (
    !host_mode && st_q.acc == PHBP_IDLE |=> st_q.acc == PHBP_IDLE)
    else $error("access started while pins are shared");
  AST_SERIAL_PINS: assert property (
    !host_mode |-> st_q.acc == PHBP_IDLE ##1 st_q.acc == PHBP_IDLE
      || pad_oe_o[PHBP_NIB_W-1:0] == serial_oe_i)
    else $error("host port active while pins are shared");
  AST_LOW_NIBBLE: assert property (
    second_serial_enable_bit_i |-> pad_o[PHBP_NIB_W-1:0] == serial_out_i)
    else $error("low nibble not given to serial port");
  AST_READ_DRIVE: assert property (
    st_q.acc == PHBP_READ && host_mode |-> pad_oe_o == '1)
    else $error("bus not driven during host read");
  AST_BUS_IDLE: assert property (
    st_q.acc != PHBP_READ |-> !st_q.bus_oe)
    else $error("bus driven outside a host read");
  AST_READ_START: assert property (
    !rw_line_mode_i && st_q.acc == PHBP_IDLE && rd_on && !wr_on
      |=> st_q.acc == PHBP_READ && st_q.bus_oe)
    else $error("output strobe did not start a read");
  AST_RW_WRITE: assert property (
    rw_line_mode_i && st_q.acc == PHBP_IDLE && wr_on |=> st_q.acc == PHBP_WRITE)
    else $error("direction line low did not start a write");
  AST_RW_READ: assert property (
    rw_line_mode_i && st_q.acc == PHBP_IDLE && rd_on |=> st_q.acc == PHBP_READ)
    else $error("direction line high did not start a read");
  AST_STROBE_LEVEL: assert property (
    rw_line_mode_i && st_q.acc == PHBP_IDLE && !ds_on |=> st_q.acc == PHBP_IDLE)
    else $error("access started with data strobe inactive");
  AST_BYTE_SEL: assert property (
    st_q.acc == PHBP_IDLE |=> st_q.hi == ($past(s_bsel) ^ $past(byte_select_invert_i)))
    else $error("byte select not taken with its configured sense");
  AST_STATUS_OUT: assert property (
    st_q.acc == PHBP_READ && st_q.stat |=> st_q.bus_out == $past(status_byte))
    else $error("status byte not presented");
  AST_WRITE_HOLD: assert property (
    st_q.acc == PHBP_WRITE && wr_on |=> st_q.acc == PHBP_WRITE)
    else $error("write ended before strobe or select rose");
  AST_IN_BUF_STABLE: assert property (
    st_q.acc != PHBP_WRITE |=> $stable(core_in_data_o))
    else $error("input buffer changed outside a write end");
  AST_CAPTURE: assert property (
    wr_done && st_q.hi |=> core_in_data_o[PHBP_BUF_W-1:PHBP_BUS_W] == $past(s_data))
    else $error("write data not captured at strobe end");
  AST_FULL_BIO: assert property (
    second_serial_enable_bit_i && bit_io_high_enable_i
      |-> vec_pad_o == bit_io_out_i[PHBP_BUS_W-1:PHBP_NIB_W])
    else $error("upper bit I/O lines not on shared pins");

  COV_WRITE: cover property (wr_done && st_q.hi);
  COV_READ: cover property (rd_done && st_q.hi && !st_q.stat);
  COV_STATUS: cover property (rd_done && st_q.stat);
  COV_RW_MODE: cover property (rw_line_mode_i && wr_done);
  COV_COMBINED: cover property (combine_flags_i && input_full_flag_o && !st_q.ibf);
endmodule
`default_nettype wire

//--- bench/phbp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module phbp_host_model
  import phbp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rw_mode_i,
  input wire logic strobe_high_i,
  input wire logic [phbp_pkg::PHBP_BUS_W-1:0] pad_i,
  output logic host_chip_select_n_o,
  output logic input_strobe_n_o,
  output logic output_strobe_n_o,
  output logic byte_select_o,
  output logic status_select_o,
  output logic [phbp_pkg::PHBP_BUS_W-1:0] bus_o
);
  import phbp_pkg::*;
  logic strobe_on;
  logic on_lvl;
  assign on_lvl = rw_mode_i & strobe_high_i;
  assign output_strobe_n_o = strobe_on ? on_lvl : ~on_lvl;
  initial begin
    host_chip_select_n_o = 1'h1;
    input_strobe_n_o = 1'h1;
    strobe_on = 1'h0;
    byte_select_o = 1'h0;
    status_select_o = 1'h0;
    bus_o = 8'hA5;
  end
  // strobe held 6 cycles, data held 4 after release: both above the synchroniser minimum
  task automatic access(input logic wr, input logic hi, input logic st, input logic sel,
    input logic [PHBP_BUS_W-1:0] d, output logic [PHBP_BUS_W-1:0] q);
    @(posedge clock_i);
    #1;
    host_chip_select_n_o = ~sel;
    byte_select_o = hi;
    status_select_o = st;
    if (wr) begin
      bus_o = d;
    end
    if (rw_mode_i) begin
      input_strobe_n_o = ~wr;
      strobe_on = 1'h1;
    end else if (wr) begin
      input_strobe_n_o = 1'h0;
    end else begin
      strobe_on = 1'h1;
    end
    repeat (6) @(posedge clock_i);
    q = pad_i;
    #1;
    host_chip_select_n_o = 1'h1;
    strobe_on = 1'h0;
    if (!rw_mode_i) begin
      input_strobe_n_o = 1'h1;
    end
    repeat (4) @(posedge clock_i);
    #1;
    // no pull-up on the bus, so a released line shows the inverse of its last value
    if (wr) begin
      bus_o = ~bus_o;
    end
    repeat (4) @(posedge clock_i);
    #1;
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import phbp_pkg::*;
  logic clock_i, rst_i, cs_n, ids_n, ods_n, bsel, stat, sse, bioh, rwm, dsah, binv, comb;
  logic crd, cwr, ibf_o, obe_o, cie, coe;
  logic [PHBP_BUS_W-1:0] hbus, pad_o, pad_oe, pad_w, st_o, bio_in, bio_out, bio_oe, rd;
  logic [PHBP_NIB_W-1:0] vpi, vpo, vpoe, sout, soe, sin, vec;
  logic [PHBP_BUF_W-1:0] cin, cout;
  int n_errors = 0;
  int n_compared = 0;
  int n_ie = 0;
  int n_oe = 0;
  assign pad_w = (pad_oe & pad_o) | (~pad_oe & hbus);
  phbp_host_port u_dut (.clock_i(clock_i), .rst_i(rst_i), .host_chip_select_n_i(cs_n),
    .input_strobe_n_i(ids_n), .output_strobe_n_i(ods_n), .byte_select_i(bsel),
    .status_select_i(stat), .pad_i(pad_w), .pad_o(pad_o), .pad_oe_o(pad_oe),
    .input_full_flag_o(ibf_o), .output_empty_flag_o(obe_o), .vec_pad_i(vpi),
    .vec_pad_o(vpo), .vec_pad_oe_o(vpoe), .second_serial_enable_bit_i(sse),
    .bit_io_high_enable_i(bioh), .rw_line_mode_i(rwm), .data_strobe_active_high_i(dsah),
    .byte_select_invert_i(binv), .combine_flags_i(comb), .core_in_data_o(cin),
    .core_in_read_i(crd), .core_in_event_o(cie), .core_out_data_i(cout),
    .core_out_write_i(cwr), .core_out_event_o(coe), .status_o(st_o),
    .serial_out_i(sout), .serial_oe_i(soe), .serial_in_o(sin), .bit_io_out_i(bio_out),
    .bit_io_oe_i(bio_oe), .bit_io_in_o(bio_in), .vector_i(vec));
  phbp_host_model u_host (.clock_i(clock_i), .rw_mode_i(rwm), .strobe_high_i(dsah),
    .pad_i(pad_w), .host_chip_select_n_o(cs_n), .input_strobe_n_o(ids_n),
    .output_strobe_n_o(ods_n), .byte_select_o(bsel), .status_select_o(stat),
    .bus_o(hbus));
  always @(posedge clock_i) begin
    if (cie === 1'h1) n_ie++;
    if (coe === 1'h1) n_oe++;
  end
  task automatic chk_val(input logic [PHBP_BUF_W-1:0] got, input logic [PHBP_BUF_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({15'h0, got}, {15'h0, exp});
  endtask
  task automatic core_op(input logic rd_n_wr, input logic [PHBP_BUF_W-1:0] d);
    @(posedge clock_i);
    #1;
    crd = rd_n_wr;
    cwr = ~rd_n_wr;
    cout = d;
    @(posedge clock_i);
    #1;
    crd = 1'h0;
    cwr = 1'h0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clock_i);
    n_errors++;
    complete_run;
  end
  initial begin
    rst_i = 1'h1;
    {sse, bioh, rwm, dsah, binv, comb, crd, cwr} = 8'h00;
    cout = 16'h0000;
    sout = 4'h5;
    soe = 4'hF;
    bio_out = 8'h3C;
    bio_oe = 8'h0F;
    vec = 4'h9;
    vpi = 4'hC;
    repeat (8) @(posedge clock_i);
    #1;
    rst_i = 1'h0;
    repeat (2) @(posedge clock_i);
    #1;
    chk_flag(ibf_o, 1'h0);
    chk_flag(obe_o, 1'h1);
    chk_val(st_o, 16'h0002);
    chk_val(pad_oe, 16'h0000);
    u_host.access(1'h1, 1'h1, 1'h0, 1'h0, 8'h77, rd);
    chk_flag(ibf_o, 1'h0);
    u_host.access(1'h1, 1'h0, 1'h0, 1'h1, 8'h34, rd);
    chk_flag(ibf_o, 1'h0);
    u_host.access(1'h1, 1'h1, 1'h0, 1'h1, 8'h12, rd);
    chk_flag(ibf_o, 1'h1);
    chk_val(cin, 16'h1234);
    chk_val(16'(n_ie), 16'h0001);
    core_op(1'h1, 16'h0000);
    chk_flag(ibf_o, 1'h0);
    core_op(1'h0, 16'hA55A);
    chk_flag(obe_o, 1'h0);
    u_host.access(1'h0, 1'h0, 1'h0, 1'h1, 8'h00, rd);
    chk_val(rd, 16'h005A);
    chk_flag(obe_o, 1'h0);
    u_host.access(1'h0, 1'h1, 1'h1, 1'h1, 8'h00, rd);
    chk_val(rd, 16'h0000);
    u_host.access(1'h0, 1'h1, 1'h0, 1'h1, 8'h00, rd);
    chk_val(rd, 16'h00A5);
    chk_flag(obe_o, 1'h1);
    chk_val(16'(n_oe), 16'h0001);
    comb = 1'h1;
    @(posedge clock_i);
    #1;
    chk_flag(ibf_o, 1'h1);
    comb = 1'h0;
    rwm = 1'h1;
    dsah = 1'h1;
    repeat (4) @(posedge clock_i);
    u_host.access(1'h1, 1'h0, 1'h0, 1'h1, 8'hCD, rd);
    u_host.access(1'h1, 1'h1, 1'h0, 1'h1, 8'hAB, rd);
    chk_val(cin, 16'hABCD);
    chk_flag(ibf_o, 1'h1);
    core_op(1'h0, 16'h0FF0);
    binv = 1'h1;
    u_host.access(1'h0, 1'h1, 1'h0, 1'h1, 8'h00, rd);
    chk_val(rd, 16'h00F0);
    u_host.access(1'h0, 1'h0, 1'h0, 1'h1, 8'h00, rd);
    chk_val(rd, 16'h000F);
    u_host.access(1'h0, 1'h0, 1'h1, 1'h1, 8'h00, rd);
    chk_val(rd, 16'h0003);
    {rwm, dsah, binv} = 3'h0;
    sse = 1'h1;
    repeat (3) @(posedge clock_i);
    chk_val(pad_oe, 16'h00FF);
    chk_val(pad_o, 16'h00C5);
    chk_val(sin, 16'h0005);
    chk_val(vpo, 16'h0009);
    u_host.access(1'h1, 1'h1, 1'h0, 1'h1, 8'h66, rd);
    chk_val(16'(n_ie), 16'h0002);
    bioh = 1'h1;
    repeat (3) @(posedge clock_i);
    chk_val(vpo, 16'h0003);
    chk_val(vpoe, 16'h0000);
    chk_val(bio_in, 16'h00CC);
    complete_run;
  end
endmodule
`default_nettype wire
